// File: hdl/osr_pkg.sv
// Shared constants, types and helpers for the one-time-programmable security store link
package osr_pkg;

  // ****************************************
  // Commands and geometry
  // ****************************************
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_PROG    = 8'h9B;
  localparam logic [7:0] OP_READ    = 8'h77;
  localparam int         USER_BYTES = 128;
  localparam logic [6:0] LOCK_LOC   = 7'h7F;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [3:0] ADDR_LAST  = 4'h4;
  localparam logic [3:0] DUMMY_SPI  = 4'h1;
  localparam logic [3:0] DUMMY_OCT  = 4'h8;

  // ****************************************
  // Pins and status layout
  // ****************************************
  localparam logic [7:0] SPI_SI_MASK   = 8'h01;
  localparam logic [7:0] SPI_SO_MASK   = 8'h02;
  localparam int         SPI_SI_BIT    = 0;
  localparam int         SPI_SO_BIT    = 1;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_LATCH_BIT = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ                       = 25;
  localparam int SECURE_STORE_PROGRAM_TIME_US  = 200;
  localparam int PROG_CYC      = SECURE_STORE_PROGRAM_TIME_US * CLK_MHZ;
  localparam logic [3:0] HOST_HALF_CYC = 4'h4;

  // Arbitrary seed for the factory unique value
  localparam logic [7:0] FACTORY_SEED = 8'h5A;

  typedef enum logic [2:0] {
    OSR_H_IDLE  = 3'b000,
    OSR_H_SETUP = 3'b001,
    OSR_H_LOW   = 3'b010,
    OSR_H_HIGH  = 3'b011,
    OSR_H_END   = 3'b100,
    OSR_H_HOLD  = 3'b101
  } osr_hstate_t;

  function automatic logic [7:0] factory_byte(input logic [6:0] idx);
    factory_byte = {1'b1, idx} ^ FACTORY_SEED;
  endfunction : factory_byte

  function automatic logic [7:0] status_byte(input logic busy, input logic latch);
    status_byte = 8'h00;
    status_byte[STAT_BUSY_BIT] = busy;
    status_byte[STAT_LATCH_BIT] = latch;
  endfunction : status_byte

endpackage : osr_pkg

// File: hdl/osr_link_if.sv
// Link wires between host and security store device
`timescale 1ns/1ps
interface osr_link_if;
  logic       cs_n;
  logic       sclk;
  logic [7:0] host_dq;
  logic [7:0] host_dq_oe_n;
  logic [7:0] dev_dq;
  logic [7:0] dev_dq_oe_n;
  logic [7:0] dq;

  // Resolved pin level, pulled high when nobody drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!host_dq_oe_n[i]) begin
        dq[i] = host_dq[i];
      end else if (!dev_dq_oe_n[i]) begin
        dq[i] = dev_dq[i];
      end else begin
        dq[i] = 1'b1;
      end
    end
  end

  modport host (output cs_n, sclk, host_dq, host_dq_oe_n, input dq);
  modport dev  (input cs_n, sclk, dq, output dev_dq, dev_dq_oe_n);
endinterface : osr_link_if

// File: hdl/osr_device.sv
// Security store device end: command decode, buffer, timed program, read
`timescale 1ns/1ps
module osr_device #(
  parameter int PROG_CYCLES = osr_pkg::PROG_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Configuration
  input  wire logic octal_mode_i,
  // Link
  osr_link_if.dev   link,
  // Status
  output logic      busy_flag_o,
  output logic      write_enable_latch_o,
  output logic      locked_o
);
  import osr_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       cs_m;
  logic       cs_s;
  logic       cs_d;
  logic       ck_m;
  logic       ck_s;
  logic       ck_d;
  logic [7:0] dq_m;
  logic [7:0] dq_s;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_d <= 1'b0;
      dq_m <= 8'h00;
      dq_s <= 8'h00;
    end else begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      ck_m <= link.sclk;
      ck_s <= ck_m;
      ck_d <= ck_s;
      dq_m <= link.dq;
      dq_s <= dq_m;
    end
  end

  // ****************************************
  // State
  // ****************************************
  logic [2:0]   cnt;
  logic [7:0]   sh;
  logic [3:0]   bcnt;
  logic [7:0]   cmd;
  logic         got_data;
  logic [6:0]   ptr;
  logic [7:0]   raddr;
  logic         rd_on;
  logic         rd_stat;
  logic [2:0]   obit;
  logic [7:0]   dev_dq;
  logic [7:0]   dev_oe_n;
  logic         busy_flag;
  logic         write_enable_latch;
  logic         locked;
  logic [15:0]  tmr;
  logic [127:0] buf_v;
  logic [127:0] marks;
  logic [7:0]   buf_mem  [USER_BYTES];
  logic [7:0]   user_mem [USER_BYTES];

  // ****************************************
  // Decode
  // ****************************************
  wire       cs_start  = !cs_s && cs_d;
  wire       cs_end    = cs_s && !cs_d;
  wire       rise      = !cs_s && ck_s && !ck_d;
  wire       fall      = !cs_s && !ck_s && ck_d;
  wire [7:0] in_byte   = octal_mode_i ? dq_s : {sh[6:0], dq_s[SPI_SI_BIT]};
  wire       byte_done = rise && (octal_mode_i || cnt == 3'h7);
  wire [3:0] dum_units = octal_mode_i ? DUMMY_OCT : DUMMY_SPI;
  wire       is_cmd    = bcnt == 4'h0;
  wire       addr_last = byte_done && bcnt == ADDR_LAST;
  wire       prog_frm  = cmd == OP_PROG && !busy_flag;
  wire       data_byte = byte_done && prog_frm && bcnt > ADDR_LAST;
  wire       prog_open = byte_done && is_cmd && in_byte == OP_PROG && !busy_flag;
  wire       rd_go     = byte_done && ((is_cmd && in_byte == OP_RDSR)
                         || (cmd == OP_READ && bcnt == ADDR_LAST + dum_units));
  wire       conflict  = locked || |(buf_v & marks);
  wire       prog_go   = cs_end && prog_frm && got_data && cnt == 3'h0
                         && write_enable_latch && !conflict;
  wire       prog_abrt = cs_end && prog_frm && !prog_go;
  wire       wren_go   = cs_end && cmd == OP_WREN && bcnt == 4'h1 && cnt == 3'h0
                         && !busy_flag;
  wire       prog_fin  = busy_flag && tmr == 16'h0000;
  wire [7:0] store_rd  = raddr[7] ? factory_byte(raddr[6:0])
                                  : user_mem[raddr[6:0]];
  wire [7:0] out_byte  = rd_stat ? status_byte(busy_flag, write_enable_latch)
                                 : store_rd;
  wire       out_bit   = out_byte[3'h7 - obit];

  // ****************************************
  // Frame shifter
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt      <= 3'h0;
      sh       <= 8'h00;
      bcnt     <= 4'h0;
      cmd      <= 8'h00;
      got_data <= 1'b0;
    end else if (cs_start) begin
      cnt      <= 3'h0;
      sh       <= 8'h00;
      bcnt     <= 4'h0;
      cmd      <= 8'h00;
      got_data <= 1'b0;
    end else if (rise) begin
      cnt <= octal_mode_i ? 3'h0 : cnt + 3'h1;
      sh  <= in_byte;
      if (byte_done && bcnt != 4'hF) begin
        bcnt <= bcnt + 4'h1;
      end
      if (byte_done && is_cmd) begin
        cmd <= in_byte;
      end
      if (data_byte) begin
        got_data <= 1'b1;
      end
    end
  end

  // ****************************************
  // Address pointers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr   <= 7'h00;
      raddr <= 8'h00;
    end else if (addr_last) begin
      ptr   <= in_byte[6:0];
      raddr <= in_byte;
    end else if (data_byte) begin
      ptr <= ptr + 7'h01;
    end else if (fall && rd_on && (octal_mode_i || obit == 3'h7)) begin
      raddr <= raddr + 8'h01;
    end
  end

  // ****************************************
  // Shared buffer
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (data_byte) begin
      buf_mem[ptr] <= in_byte;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_v <= '0;
    end else if (prog_open) begin
      buf_v <= '0;
    end else if (data_byte) begin
      buf_v[ptr] <= 1'b1;
    end
  end

  // ****************************************
  // Read output
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_on    <= 1'b0;
      rd_stat  <= 1'b0;
      obit     <= 3'h0;
      dev_dq   <= 8'h00;
      dev_oe_n <= 8'hFF;
    end else if (cs_s) begin
      rd_on    <= 1'b0;
      rd_stat  <= 1'b0;
      obit     <= 3'h0;
      dev_oe_n <= 8'hFF;
    end else if (rd_go) begin
      rd_on   <= 1'b1;
      rd_stat <= is_cmd;
    end else if (fall && rd_on) begin
      dev_dq   <= octal_mode_i ? out_byte : (out_bit ? SPI_SO_MASK : 8'h00);
      dev_oe_n <= octal_mode_i ? 8'h00 : ~SPI_SO_MASK;
      obit     <= octal_mode_i ? 3'h0 : obit + 3'h1;
    end
  end

  // ****************************************
  // Write enable and timed program
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_enable_latch <= 1'b0;
    end else if (wren_go) begin
      write_enable_latch <= 1'b1;
    end else if (prog_go || prog_abrt) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_flag <= 1'b0;
      tmr       <= 16'h0000;
    end else if (prog_go) begin
      busy_flag <= 1'b1;
      tmr       <= 16'(PROG_CYCLES - 1);
    end else if (prog_fin) begin
      busy_flag <= 1'b0;
    end else if (busy_flag) begin
      tmr <= tmr - 16'h0001;
    end
  end

  // Only buffered locations change; others keep their contents
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked <= 1'b0;
      marks  <= '0;
      for (int i = 0; i < USER_BYTES; i++) begin
        user_mem[i] <= ERASED;
      end
    end else if (prog_fin) begin
      locked <= locked | buf_v[LOCK_LOC];
      marks  <= marks | buf_v;
      for (int i = 0; i < USER_BYTES; i++) begin
        if (buf_v[i]) begin
          user_mem[i] <= buf_mem[i];
        end
      end
    end
  end

  assign link.dev_dq          = dev_dq;
  assign link.dev_dq_oe_n     = dev_oe_n;
  assign busy_flag_o          = busy_flag;
  assign write_enable_latch_o = write_enable_latch;
  assign locked_o             = locked;

endmodule : osr_device

// File: hdl/osr_host.sv
// Host end: frames commands on the serial or octal link
`timescale 1ns/1ps
module osr_host (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // Request
  input  wire logic        octal_mode_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [8:0]  len_i,
  input  wire logic [2:0]  tail_bits_i,
  input  wire logic [7:0]  wdata_i,
  // Answer
  output logic             wdata_take_o,
  output logic [7:0]       rdata_o,
  output logic             rdata_valid_o,
  output logic             done_o,
  output logic             busy_o,
  // Link
  osr_link_if.host         link
);
  import osr_pkg::*;

  osr_hstate_t state;
  logic [3:0]  dc;
  logic        oct;
  logic [7:0]  cmd;
  logic [31:0] addr;
  logic [8:0]  len;
  logic [2:0]  tail;
  logic        in_tail;
  logic [9:0]  unit;
  logic [2:0]  bitc;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic        cs_n;
  logic        sclk;
  logic [7:0]  hdq;
  logic [7:0]  hoe_n;
  logic [7:0]  dq_m;
  logic [7:0]  dq_s;

  // ****************************************
  // Decode
  // ****************************************
  wire       has_addr  = cmd == OP_PROG || cmd == OP_READ;
  wire       is_rd     = cmd == OP_READ || cmd == OP_RDSR;
  wire [9:0] hdr       = 10'h001 + (has_addr ? 10'h004 : 10'h000)
                         + (cmd == OP_READ ? {6'h00, oct ? DUMMY_OCT : DUMMY_SPI} : 10'h000);
  wire [9:0] total     = hdr + {1'b0, len};
  wire [9:0] nunit     = unit + 10'h001;
  wire       unit_last = oct || bitc == 3'h7;
  wire       rd_unit   = is_rd && unit >= hdr && !in_tail;
  wire       drv_unit  = in_tail || unit < (has_addr ? 10'h005 : 10'h001) || cmd == OP_PROG;
  wire [7:0] nbyte     = nunit > 10'h004 ? wdata_i : 8'(addr >> (8 * (4 - nunit[2:0])));
  wire       take      = cmd == OP_PROG && nunit >= hdr;
  wire       half_done = dc == 4'h0;
  wire [7:0] rx_next   = oct ? dq_s : {rx[6:0], dq_s[SPI_SO_BIT]};
  wire       frame_on  = state == OSR_H_LOW || state == OSR_H_HIGH || state == OSR_H_SETUP;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dq_m <= 8'h00;
      dq_s <= 8'h00;
    end else begin
      dq_m <= link.dq;
      dq_s <= dq_m;
    end
  end

  // ****************************************
  // Frame sequencer
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state         <= OSR_H_IDLE;
      dc            <= 4'h0;
      oct           <= 1'b0;
      cmd           <= 8'h00;
      addr          <= 32'h0000_0000;
      len           <= 9'h000;
      tail          <= 3'h0;
      in_tail       <= 1'b0;
      unit          <= 10'h000;
      bitc          <= 3'h0;
      tx            <= 8'h00;
      rx            <= 8'h00;
      cs_n          <= 1'b1;
      sclk          <= 1'b0;
      wdata_take_o  <= 1'b0;
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
      done_o        <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      wdata_take_o  <= 1'b0;
      rdata_valid_o <= 1'b0;
      done_o        <= 1'b0;
      dc            <= half_done ? HOST_HALF_CYC - 4'h1 : dc - 4'h1;
      case (state)
        OSR_H_IDLE: begin
          dc <= HOST_HALF_CYC - 4'h1;
          if (start_i) begin
            oct     <= octal_mode_i;
            cmd     <= cmd_i;
            addr    <= addr_i;
            len     <= len_i;
            tail    <= tail_bits_i;
            in_tail <= 1'b0;
            unit    <= 10'h000;
            bitc    <= 3'h0;
            tx      <= cmd_i;
            cs_n    <= 1'b0;
            busy_o  <= 1'b1;
            state   <= OSR_H_SETUP;
          end
        end
        OSR_H_SETUP, OSR_H_LOW: begin
          if (half_done) begin
            sclk  <= 1'b1;
            state <= OSR_H_HIGH;
          end
        end
        OSR_H_HIGH: begin
          if (half_done) begin
            sclk  <= 1'b0;
            state <= OSR_H_LOW;
            if (rd_unit) begin
              rx <= rx_next;
              if (unit_last) begin
                rdata_o       <= rx_next;
                rdata_valid_o <= 1'b1;
              end
            end
            if (in_tail) begin
              tail <= tail - 3'h1;
              if (tail == 3'h1) begin
                state <= OSR_H_END;
              end
            end else if (!unit_last) begin
              bitc <= bitc + 3'h1;
              tx   <= {tx[6:0], 1'b0};
            end else if (nunit == total) begin
              tx <= 8'hFF;
              if (tail != 3'h0 && !oct) begin
                in_tail <= 1'b1;
              end else begin
                state <= OSR_H_END;
              end
            end else begin
              unit         <= nunit;
              bitc         <= 3'h0;
              tx           <= nbyte;
              wdata_take_o <= take;
            end
          end
        end
        OSR_H_END: begin
          if (half_done) begin
            cs_n  <= 1'b1;
            state <= OSR_H_HOLD;
          end
        end
        OSR_H_HOLD: begin
          if (half_done) begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state  <= OSR_H_IDLE;
          end
        end
        default: state <= OSR_H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hdq   <= 8'h00;
      hoe_n <= 8'hFF;
    end else begin
      hdq <= oct ? tx : (tx[7] ? SPI_SI_MASK : 8'h00);
      if (frame_on && (!oct || drv_unit)) begin
        hoe_n <= oct ? 8'h00 : ~SPI_SI_MASK;
      end else begin
        hoe_n <= 8'hFF;
      end
    end
  end

  assign link.cs_n         = cs_n;
  assign link.sclk         = sclk;
  assign link.host_dq      = hdq;
  assign link.host_dq_oe_n = hoe_n;

endmodule : osr_host

// File: dv/osr_checker.sv
// Concurrent checks on the link between the host and store ends
`timescale 1ns/1ps
module osr_checker #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  // Link
  input wire logic       octal_mode_i,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [7:0] host_dq_oe_n,
  input wire logic [7:0] dev_dq_oe_n,
  // Store status
  input wire logic       busy_flag_o,
  input wire logic       write_enable_latch_o,
  input wire logic       locked_o
);
  logic [15:0] bcnt;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Length of the busy stretch
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) bcnt <= '0;
    else bcnt <= busy_flag_o ? bcnt + 16'h1 : '0;
  end

  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  AST_DEV_RELEASE: assert property ($rose(cs_n) |-> ##[0:4] dev_dq_oe_n == 8'hFF)
    else $error("store pins not released after deselect");
  AST_DEV_QUIET: assert property (cs_n [*5] |-> dev_dq_oe_n == 8'hFF)
    else $error("store drives while deselected");
  AST_NO_FIGHT: assert property ((~host_dq_oe_n & ~dev_dq_oe_n) == 8'h00)
    else $error("both ends drive one pin");
  AST_SINGLE_PIN: assert property (!octal_mode_i |-> (dev_dq_oe_n | 8'h02) == 8'hFF)
    else $error("single mode output on wrong pin");
  AST_LATCH_BUSY: assert property ($rose(busy_flag_o) |-> ##[0:1] !write_enable_latch_o)
    else $error("write enable latch kept while programming");
  AST_BUSY_AFTER_CS: assert property ($rose(busy_flag_o) |-> cs_n && $past(cs_n, 3))
    else $error("programming began before deselect");
  AST_BUSY_LEN: assert property ($fell(busy_flag_o) |->
                                 bcnt >= PROG_CYCLES - 1 && bcnt <= PROG_CYCLES + 1)
    else $error("programming time wrong");
  AST_LOCK_KEEP: assert property (locked_o |=> locked_o)
    else $error("lock lost");

  cover property ($fell(busy_flag_o));
  cover property ($rose(locked_o));
  cover property ($fell(write_enable_latch_o) && !busy_flag_o);
endmodule : osr_checker

// File: dv/tb_top.sv
// Self-checking bench: host and store ends joined over the link
`timescale 1ns/1ps
module tb_top;
  import osr_pkg::*;
  localparam int PCY = 300;
  logic        clk;
  logic        nrst;
  logic        octal;
  logic        start;
  logic [7:0]  cmd;
  logic [31:0] addr;
  logic [8:0]  len;
  logic [2:0]  tail;
  logic [7:0]  wdata;
  logic        take;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        done;
  logic        hbusy;
  logic        busy;
  logic        wen_latch;
  logic        locked;
  logic [7:0]  mem [256];
  logic [7:0]  wq [$];
  logic [7:0]  rq [$];
  int          fails;
  int          n_tests;
  int          cyc;
  int          seed;
  logic [31:0] r;

  osr_link_if lnk ();
  osr_host i_osr_host (.sys_clk_i(clk), .nrst_i(nrst), .octal_mode_i(octal), .start_i(start),
    .cmd_i(cmd), .addr_i(addr), .len_i(len), .tail_bits_i(tail), .wdata_i(wdata),
    .wdata_take_o(take), .rdata_o(rdata), .rdata_valid_o(rvalid), .done_o(done),
    .busy_o(hbusy), .link(lnk));
  osr_device #(.PROG_CYCLES(PCY)) i_osr_device (.sys_clk_i(clk), .nrst_i(nrst),
    .octal_mode_i(octal), .link(lnk), .busy_flag_o(busy), .write_enable_latch_o(wen_latch),
    .locked_o(locked));
  osr_checker #(.PROG_CYCLES(PCY)) i_osr_checker (.sys_clk_i(clk), .nrst_i(nrst),
    .octal_mode_i(octal), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .host_dq_oe_n(lnk.host_dq_oe_n),
    .dev_dq_oe_n(lnk.dev_dq_oe_n), .busy_flag_o(busy), .write_enable_latch_o(wen_latch),
    .locked_o(locked));

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk8

  // One host frame; feeds write bytes, gathers read bytes
  task automatic xfer(input logic [7:0] c, input logic [31:0] a, input logic [8:0] n,
                      input logic [2:0] t);
    int k;
    int w;
    k = 0;
    w = 0;
    rq.delete();
    @(negedge clk);
    {cmd, addr, len, tail} = {c, a, n, t};
    wdata = (wq.size() > 0) ? wq[0] : 8'h00;
    start = 1'b1;
    do begin
      @(negedge clk);
      start = 1'b0;
      k++;
      if (k == 1) chk8("host busy", 8'h01, {7'h00, hbusy});
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (take === 1'b1) begin
        w++;
        if (w < wq.size()) wdata = wq[w];
      end
    end while (done !== 1'b1 && k < 30000);
    chk8("host idle", 8'h00, {7'h00, hbusy});
    if (k >= 30000) fails++;
  endtask : xfer

  task automatic fresh();
    for (int i = 0; i < 256; i++) begin
      mem[i] = (i < USER_BYTES) ? ERASED : ({1'b1, 7'(i)} ^ FACTORY_SEED);
    end
  endtask : fresh

  task automatic commit(input logic [6:0] a);
    foreach (wq[k]) mem[7'(a + k)] = wq[k];
  endtask : commit

  task automatic rd(input logic [31:0] a, input logic [8:0] n, input logic [2:0] t);
    xfer(OP_READ, a, n, t);
    chk8("read count", n[7:0], 8'(rq.size()));
    chk8("read count high", {7'h00, n[8]}, 8'(rq.size() >> 8));
    foreach (rq[i]) chk8("read byte", mem[8'(a + i)], rq[i]);
  endtask : rd

  task automatic st(input logic [7:0] e);
    xfer(OP_RDSR, 32'h0, 9'h1, 3'h0);
    chk8("status", e, rq[0]);
  endtask : st

  task automatic poll();
    int k;
    k = 0;
    do begin
      xfer(OP_RDSR, 32'h0, 9'h1, 3'h0);
      k++;
    end while (rq[0][STAT_BUSY_BIT] !== 1'b0 && k < 20);
    chk8("ready status", 8'h00, rq[0]);
  endtask : poll

  task automatic prog(input logic [31:0] a, input logic [8:0] n, input logic [2:0] t,
                      input logic wen);
    wq.delete();
    if (wen) xfer(OP_WREN, 32'h0, 9'h0, 3'h0);
    repeat (n) wq.push_back(8'($random(seed)));
    xfer(OP_PROG, a, n, t);
  endtask : prog

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 60000) begin
        fails++;
        stop_test();
      end
    end
  end

  initial begin
    seed = 32'hE2D92421;
    {nrst, octal, start, cmd, addr, len, tail, wdata} = '0;
    fails = 0;
    n_tests = 0;
    fresh();
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    for (int m = 0; m < 2; m++) begin
      octal = m[0];
      r = $random(seed);
      rd(r, 9'h100, m ? 3'h0 : 3'h3);
      st(8'h00);
    end
    octal = 1'b0;
    $display("Test done: whole store read");
    for (int c = 0; c < 3; c++) begin
      prog(32'h30, (c == 1) ? 9'h0 : 9'h1, (c == 0) ? 3'h3 : 3'h0, c < 2);
      st(8'h00);
    end
    $display("Test done: aborted programs");
    xfer(OP_WREN, 32'h0, 9'h0, 3'h0);
    st(8'h02);
    r = $random(seed);
    prog({r[31:7], 7'h10}, 9'h3, 3'h0, 1'b0);
    commit(7'h10);
    st(8'h01);
    poll();
    prog(32'h11, 9'h1, 3'h0, 1'b1);
    st(8'h00);
    $display("Test done: program and overwrite");
    prog({r[31:7], 7'h7E}, 9'h3, 3'h0, 1'b1);
    commit(7'h7E);
    poll();
    chk8("locked", 8'h01, {7'h00, locked});
    prog(32'h40, 9'h1, 3'h0, 1'b1);
    st(8'h00);
    rd(32'h0, 9'h80, 3'h0);
    $display("Test done: wrap and lock");
    @(negedge clk);
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    fresh();
    octal = 1'b1;
    prog({r[31:8], 8'h85}, 9'h82, 3'h0, 1'b1);
    commit(7'h05);
    poll();
    rd(32'h0, 9'h80, 3'h0);
    chk8("locked", 8'h01, {7'h00, locked});
    $display("Test done: long octal program");
    stop_test();
  end
endmodule : tb_top
